// ### include/tls_consts.vh
// Purpose: constants for the transmit and link status register bank
// Assumes: register port with 4-bit word addresses, 16-bit data
// Notes: offsets are word indices on the plain register port
`ifndef TLS_CONSTS_VH
`define TLS_CONSTS_VH

`define TLS_ADDR_W 4
`define TLS_DATA_W 16

`define TLS_OFS_TXSTAT 4'h0
`define TLS_OFS_GENSTAT 4'h1
`define TLS_OFS_TXCTRL 4'h2
`define TLS_OFS_IRQ_STAT 4'h3
`define TLS_OFS_IRQ_MASK 4'h4

`define TLS_RST_TXSTAT 16'h0000
`define TLS_RST_GENSTAT 16'h0000
`define TLS_RST_IRQ 4'h0

// transmit status field positions
`define TLS_TX_TX_COLLISION_TALLY_LSB 0
`define TLS_TX_FCS_BIT 4
`define TLS_TX_WAIT_BIT 7
`define TLS_TX_EXWAIT_BIT 8
`define TLS_TX_TX_COLLISION_LIMIT_ABORT_BIT 9

// general status field positions
`define TLS_GS_INT_BIT 15
`define TLS_GS_PAUSE_IDLE_BIT 14
`define TLS_GS_RX_ACTIVE_BIT 13
`define TLS_GS_CLK_OK_BIT 12
`define TLS_GS_DUPLEX_BIT 10
`define TLS_GS_LINK_BIT 8

// transmit control: bit 0 is the send request
`define TLS_TXCTRL_SEND_BIT 0

// interrupt status/mask bit positions
`define TLS_IRQ_TXDONE 0
`define TLS_IRQ_LINK 1
`define TLS_IRQ_FCS 2
`define TLS_IRQ_TX_COLLISION_LIMIT_ABORT 3
`define TLS_IRQ_W 4

`endif

// ### logic/tls_sync2.v
// Purpose: two-flop synchroniser for a bundle of level inputs
// Assumes: inputs are quasi-static levels from outside the clk_sys domain
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module tls_sync2 #(
    parameter WIDTH = 4
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_q;
reg [WIDTH-1:0] sync_q;

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        meta_q <= {WIDTH{1'b0}};
        sync_q <= {WIDTH{1'b0}};
    end else begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end
end

assign sync_out = sync_q;

endmodule

`default_nettype wire

// ### logic/tls_status_regs.v
// Purpose: transmit outcome and general controller status registers
// Assumes: transmit engine reports one outcome pulse per frame; line pins async
// Notes: transmit outcome latched at frame end; reads return data a cycle later
//
// Summary of operation
// [R1] On frame end the wait flag is set when the sender had to hold off for traffic.
// [R2] The wait flag is cleared when there was no hold-off or the hold-off became excessive.
// [R3] The FCS mismatch flag is set when the sent check field differs from the computed CRC.
// [R4] The FCS mismatch flag stays clear on a good check field or when CRC append is on.
// [R5] Collision, collision-limit, wait and excessive-wait bits update only in half duplex.
// [R6] Software ignores reserved transmit status bits 6-5, which read as zero here.
// [R7] The collision tally of the last frame sits in transmit status bits 3-0.
// [R8] The send request bit clears itself when the frame transmission completes.
// [R9] The link bit is set while a link partner is present and clear otherwise.
// [R10] The duplex bit is set while the line runs full duplex.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tls_consts.vh"

module tls_status_regs #(
    parameter ADDR_W = `TLS_ADDR_W,
    parameter DATA_W = `TLS_DATA_W
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [DATA_W-1:0] reg_rdata,
    output wire irq,
    output wire tx_send_request,
    input wire tx_done,
    input wire tx_had_wait,
    input wire tx_wait_excessive,
    input wire tx_fcs_bad,
    input wire tx_crc_append,
    input wire [3:0] tx_collisions,
    input wire tx_collision_abort,
    input wire line_link_up,
    input wire line_full_duplex,
    input wire pause_idle,
    input wire rx_active,
    input wire clock_ok,
    input wire [7:0] rx_frame_count
);

//------------------------------------------------------------
// input synchronisation
//------------------------------------------------------------
wire [3:0] line_sync;
wire line_link_up_flag;
wire line_full_duplex_flag;
wire pause_machine_idle;
wire internal_clock_ok;

tls_sync2 #(
    .WIDTH(4)
) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({clock_ok, pause_idle, line_full_duplex, line_link_up}),
    .sync_out(line_sync)
);

assign line_link_up_flag = line_sync[0];
assign line_full_duplex_flag = line_sync[1];
assign pause_machine_idle = line_sync[2];
assign internal_clock_ok = line_sync[3];

//------------------------------------------------------------
// register state
//------------------------------------------------------------
reg [3:0] tx_collision_tally_q;
reg tx_fcs_mismatch_flag_q;
reg tx_wait_flag_q;
reg tx_excessive_wait_flag_q;
reg tx_collision_limit_abort_q;
reg tx_send_request_q;
reg link_prev_q;
reg [`TLS_IRQ_W-1:0] irq_stat_q;
reg [`TLS_IRQ_W-1:0] irq_mask_q;
reg [`TLS_IRQ_W-1:0] irq_event;

// register write decode
function addr_hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] ofs;
    begin
        addr_hit = (addr == ofs);
    end
endfunction

wire wr_txctrl = reg_wr && addr_hit(reg_addr, `TLS_OFS_TXCTRL);
wire wr_istat = reg_wr && addr_hit(reg_addr, `TLS_OFS_IRQ_STAT);
wire wr_imask = reg_wr && addr_hit(reg_addr, `TLS_OFS_IRQ_MASK);
wire frame_end = tx_done && tx_send_request_q;

//------------------------------------------------------------
// transmit outcome capture
//------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        tx_collision_tally_q <= 4'h0;
        tx_fcs_mismatch_flag_q <= 1'b0;
        tx_wait_flag_q <= 1'b0;
        tx_excessive_wait_flag_q <= 1'b0;
        tx_collision_limit_abort_q <= 1'b0;
    end else if (frame_end) begin
        tx_fcs_mismatch_flag_q <= tx_fcs_bad && !tx_crc_append; // [R3] [R4]
        if (!line_full_duplex_flag) begin // [R5]
            tx_collision_tally_q <= tx_collisions; // [R7]
            tx_collision_limit_abort_q <= tx_collision_abort;
            tx_excessive_wait_flag_q <= tx_wait_excessive;
            tx_wait_flag_q <= tx_had_wait && !tx_wait_excessive; // [R1] [R2]
        end
    end
end

//------------------------------------------------------------
// send request, self-clearing on completion
//------------------------------------------------------------
always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        tx_send_request_q <= 1'b0;
    end else if (frame_end) begin
        tx_send_request_q <= 1'b0; // [R8]
    end else if (wr_txctrl && reg_wdata[`TLS_TXCTRL_SEND_BIT]) begin
        tx_send_request_q <= 1'b1;
    end
end

assign tx_send_request = tx_send_request_q;

//------------------------------------------------------------
// interrupts: sticky, write one to clear, set wins
//------------------------------------------------------------
// a link change is flagged on either edge of the synced link bit
always @* begin
    irq_event = {`TLS_IRQ_W{1'b0}};
    irq_event[`TLS_IRQ_TXDONE] = frame_end;
    irq_event[`TLS_IRQ_LINK] = line_link_up_flag ^ link_prev_q;
    irq_event[`TLS_IRQ_FCS] = frame_end && tx_fcs_bad && !tx_crc_append;
    irq_event[`TLS_IRQ_TX_COLLISION_LIMIT_ABORT] = frame_end && tx_collision_abort && !line_full_duplex_flag;
end

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        link_prev_q <= 1'b0;
        irq_stat_q <= `TLS_RST_IRQ;
        irq_mask_q <= `TLS_RST_IRQ;
    end else begin
        link_prev_q <= line_link_up_flag;
        if (wr_istat) begin
            irq_stat_q <= (irq_stat_q & ~reg_wdata[`TLS_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_stat_q <= irq_stat_q | irq_event;
        end
        if (wr_imask) begin
            irq_mask_q <= reg_wdata[`TLS_IRQ_W-1:0];
        end
    end
end

assign irq = |(irq_stat_q & irq_mask_q);

//------------------------------------------------------------
// read mux
//------------------------------------------------------------
function [DATA_W-1:0] tx_word;
    input [3:0] tally;
    input fcs;
    input wflag;
    input exw;
    input maxc;
    begin
        tx_word = `TLS_RST_TXSTAT;
        tx_word[`TLS_TX_TX_COLLISION_TALLY_LSB +: 4] = tally; // [R7]
        tx_word[`TLS_TX_FCS_BIT] = fcs;
        tx_word[`TLS_TX_WAIT_BIT] = wflag;
        tx_word[`TLS_TX_EXWAIT_BIT] = exw;
        tx_word[`TLS_TX_TX_COLLISION_LIMIT_ABORT_BIT] = maxc;
    end
endfunction

function [DATA_W-1:0] irq_word;
    input [`TLS_IRQ_W-1:0] bits;
    begin
        irq_word = {{(DATA_W-`TLS_IRQ_W){1'b0}}, bits};
    end
endfunction

reg [DATA_W-1:0] gen_word;

always @* begin
    gen_word = `TLS_RST_GENSTAT;
    gen_word[`TLS_GS_INT_BIT] = irq;
    gen_word[`TLS_GS_PAUSE_IDLE_BIT] = pause_machine_idle;
    gen_word[`TLS_GS_RX_ACTIVE_BIT] = rx_active;
    gen_word[`TLS_GS_CLK_OK_BIT] = internal_clock_ok;
    gen_word[`TLS_GS_DUPLEX_BIT] = line_full_duplex_flag; // [R10]
    gen_word[`TLS_GS_LINK_BIT] = line_link_up_flag; // [R9]
    gen_word[7:0] = rx_frame_count;
end

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        reg_rdata <= {DATA_W{1'b0}};
    end else if (reg_rd) begin
        case (reg_addr)
            `TLS_OFS_TXSTAT: reg_rdata <= tx_word(tx_collision_tally_q,
                tx_fcs_mismatch_flag_q, tx_wait_flag_q, tx_excessive_wait_flag_q,
                tx_collision_limit_abort_q); // [R6]
            `TLS_OFS_GENSTAT: reg_rdata <= gen_word;
            `TLS_OFS_TXCTRL: reg_rdata <= {{(DATA_W-1){1'b0}}, tx_send_request_q};
            `TLS_OFS_IRQ_STAT: reg_rdata <= irq_word(irq_stat_q);
            `TLS_OFS_IRQ_MASK: reg_rdata <= irq_word(irq_mask_q);
            default: reg_rdata <= {DATA_W{1'b0}};
        endcase
    end else begin
        reg_rdata <= {DATA_W{1'b0}};
    end
end

endmodule

`default_nettype wire

// ### sim/tls_status_regs_props.sv
// Purpose: port checks on the transmit and line status register bank
// Assumes: one clock domain; duplex and link pass two flops inside
// Notes: expected transmit outcome is mirrored in helper logic
`timescale 1ns/100ps
`default_nettype none
module tls_status_regs_props (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic irq,
    input wire logic tx_send_request,
    input wire logic tx_done,
    input wire logic tx_had_wait,
    input wire logic tx_wait_excessive,
    input wire logic tx_fcs_bad,
    input wire logic tx_crc_append,
    input wire logic [3:0] tx_collisions,
    input wire logic tx_collision_abort,
    input wire logic line_link_up,
    input wire logic line_full_duplex
);
    logic [1:0] dpx_q;
    logic [1:0] lnk_q;
    logic [9:0] exp_q;
    wire fin = tx_send_request & tx_done;
    wire rd_tx = reg_rd & (reg_addr == 4'h0);
    wire rd_gs = reg_rd & (reg_addr == 4'h1);
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dpx_q <= 2'h0;
            lnk_q <= 2'h0;
            exp_q <= 10'h000;
        end else begin
            dpx_q <= {dpx_q[0], line_full_duplex};
            lnk_q <= {lnk_q[0], line_link_up};
            if (fin)
                exp_q[4] <= tx_fcs_bad & ~tx_crc_append;
            if (fin & ~dpx_q[1]) begin
                exp_q[3:0] <= tx_collisions;
                exp_q[9:7] <= {tx_collision_abort, tx_wait_excessive,
                    tx_had_wait & ~tx_wait_excessive};
            end
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_tally_field: assert property (rd_tx |=> reg_rdata[3:0] == $past(exp_q[3:0]))
        else $error("collision tally wrong");
    chk_wait_flag: assert property (rd_tx |=> reg_rdata[7] == $past(exp_q[7]))
        else $error("wait flag wrong");
    chk_half_only: assert property (rd_tx |=> reg_rdata[9:8] == $past(exp_q[9:8]))
        else $error("excessive wait or limit flag wrong");
    chk_fcs_flag: assert property (rd_tx |=> reg_rdata[4] == $past(exp_q[4]))
        else $error("fcs flag wrong");
    chk_reserved_zero: assert property (rd_tx |=> reg_rdata[6:5] == 2'h0)
        else $error("reserved bits set");
    chk_send_clear: assert property (fin |=> !tx_send_request)
        else $error("send request not cleared");
    chk_duplex_bit: assert property (rd_gs |=> reg_rdata[10] == $past(dpx_q[1]))
        else $error("duplex bit wrong");
    chk_link_bit: assert property (rd_gs |=> reg_rdata[8] == $past(lnk_q[1]))
        else $error("link bit wrong");
    cover property (fin && dpx_q[1]);
    cover property (fin && tx_crc_append);
    cover property (irq);
endmodule
bind tls_status_regs tls_status_regs_props u_props (.clk_sys, .reset_n, .reg_addr, .reg_rd,
    .reg_rdata, .irq, .tx_send_request, .tx_done, .tx_had_wait, .tx_wait_excessive,
    .tx_fcs_bad, .tx_crc_append, .tx_collisions, .tx_collision_abort, .line_link_up,
    .line_full_duplex);
`default_nettype wire

// ### sim/tb.sv
// Purpose: self-checking bench for the status register bank
// Assumes: register port answers reads one cycle later
// Notes: line inputs held steady several cycles before being read
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, tx_done = 0, tx_had_wait = 0;
    logic tx_wait_excessive = 0, tx_fcs_bad = 0, tx_crc_append = 0, tx_collision_abort = 0;
    logic line_link_up = 0, line_full_duplex = 0, pause_idle = 0, rx_active = 0, clock_ok = 0;
    logic [3:0] reg_addr = 4'h0, tx_collisions = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, exp_tx = 16'h0000;
    logic [7:0] rx_frame_count = 8'h00;
    wire [15:0] reg_rdata;
    wire irq, tx_send_request;
    int error_cnt = 0, samples_checked = 0;
    tls_status_regs dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .tx_send_request, .tx_done, .tx_had_wait, .tx_wait_excessive,
        .tx_fcs_bad, .tx_crc_append, .tx_collisions, .tx_collision_abort, .line_link_up,
        .line_full_duplex, .pause_idle, .rx_active, .clock_ok, .rx_frame_count);
    always #5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask
    task automatic frame(input logic w, x, f, a, m, fd, input logic [3:0] c);
        wr(4'h2, 16'h0001);
        #1 chk("send_request", 16'h0001, {15'h0000, tx_send_request});
        rd(4'h2, 16'h0001, "tx_ctrl_pending");
        @(posedge clk_sys);
        {tx_had_wait, tx_wait_excessive, tx_fcs_bad} <= {w, x, f};
        {tx_crc_append, tx_collision_abort} <= {a, m};
        tx_collisions <= c;
        tx_done <= 1'b1;
        @(posedge clk_sys);
        tx_done <= 1'b0;
        #1 chk("send_request", 16'h0000, {15'h0000, tx_send_request});
        if (!fd)
            exp_tx = {6'h00, m, x, w & ~x, 3'h0, c};
        exp_tx[4] = f & ~a;
        rd(4'h0, exp_tx, "tx_status");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(4'h1, 16'h0000, "gen_status_reset");
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'h0000, "tx_status_read_only");
        rd(4'hF, 16'h0000, "unmapped");
        $display("test reset_and_access done");
        frame(1, 0, 1, 0, 0, 0, 4'h5);
        frame(1, 1, 1, 1, 1, 0, 4'hF);
        frame(0, 0, 0, 0, 0, 0, 4'h0);
        // frame end with no send request pending must leave the status alone
        @(posedge clk_sys);
        tx_collisions <= 4'h9;
        tx_done <= 1'b1;
        @(posedge clk_sys);
        tx_done <= 1'b0;
        rd(4'h0, exp_tx, "tx_status_no_request");
        @(posedge clk_sys);
        line_full_duplex <= 1'b1;
        repeat (4) @(posedge clk_sys);
        frame(1, 0, 1, 0, 1, 1, 4'h3);
        $display("test frames done");
        @(posedge clk_sys);
        {line_link_up, pause_idle, rx_active, clock_ok} <= 4'hF;
        rx_frame_count <= 8'hA5;
        repeat (4) @(posedge clk_sys);
        rd(4'h1, 16'h75A5, "gen_status");
        @(posedge clk_sys);
        {line_link_up, line_full_duplex} <= 2'h0;
        repeat (4) @(posedge clk_sys);
        rd(4'h1, 16'h70A5, "gen_status_down");
        $display("test line_status done");
        rd(4'h3, 16'h000F, "irq_status");
        wr(4'h4, 16'h0001);
        #1 chk("irq", 16'h0001, {15'h0000, irq});
        rd(4'h4, 16'h0001, "irq_mask");
        wr(4'h3, 16'h0001);
        #1 chk("irq", 16'h0000, {15'h0000, irq});
        rd(4'h3, 16'h000E, "irq_status_cleared");
        rd(4'h2, 16'h0000, "tx_ctrl_idle");
        $display("test interrupt done");
        @(posedge clk_sys);
        reset_n <= 1'b0;
        @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(4'h0, 16'h0000, "tx_status_after_reset");
        rd(4'h3, 16'h0000, "irq_status_after_reset");
        chk("irq", 16'h0000, {15'h0000, irq});
        $display("test mid_reset done");
        complete_run;
    end
    initial begin
        #100000;
        error_cnt++;
        complete_run;
    end
endmodule
`default_nettype wire
